// File: logic/ssr_regs.vh
/*
 * Register map, field positions, reset values and timing constants of the sensor
 * status readout block. Assumes a 100 MHz system clock.
 */
// Summary of operation
// - Time counter bits 23..16 readable as a byte, one count is 2.56 s.
// - Power-on flag bit 0 is set after power-up and soft reset, reset value 0x01.
// - Reading the event register clears the power-on flag.
// - Reading the feature status register clears all of its set bits.
// - Feature flags at bits 7,6,5,3,2,1; bits 4 and 0 read zero.
// - Reading the data and FIFO status register clears all of its set bits.
// - Data flags at bits 7,5,1,0; all other bits read zero.
// - Step count is 32 bits over bytes 0x1E (low) to 0x21 (high).
// - Temperature byte is two's complement, one kelvin per count, 0x00 is 23 C.
// - Register 0x24 returns FIFO byte count bits 7..0.
// - Register 0x25 returns FIFO byte count bits 13..8, upper two bits zero.
// - Time counter is 24 bits, its lowest bit is 39.0625 us.
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SSR_ADDR_TIME_HIGH      8'h1A
`define SSR_ADDR_POR_EVENT      8'h1B
`define SSR_ADDR_FEAT_STATUS    8'h1C
`define SSR_ADDR_DATA_STATUS    8'h1D
`define SSR_ADDR_STEP0          8'h1E
`define SSR_ADDR_STEP1          8'h1F
`define SSR_ADDR_STEP2          8'h20
`define SSR_ADDR_STEP3          8'h21
`define SSR_ADDR_TEMPERATURE    8'h22
`define SSR_ADDR_FIFO_LOW       8'h24
`define SSR_ADDR_FIFO_HIGH      8'h25
`define SSR_ADDR_IRQ_ENABLE     8'h30
`define SSR_ADDR_IRQ_STATUS     8'h31
`define SSR_ADDR_IRQ_CLEAR      8'h32

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define SSR_FEAT_MASK           8'hEE
`define SSR_DATA_MASK           8'hA3
`define SSR_POR_BIT             0
`define SSR_POR_RESET           8'h01
`define SSR_ZERO                8'h00
`define SSR_FIFO_HIGH_MASK      8'h3F
`define SSR_IRQ_POR_BIT         0
`define SSR_IRQ_FEAT_BIT        1
`define SSR_IRQ_DATA_BIT        2
`define SSR_IRQ_MASK            8'h07

// ----------------------------------------------------------------------------
// Timing: time counter tick in picoseconds and cycles per tick
// ----------------------------------------------------------------------------
`define SSR_TICK_PS             39062500
`define SSR_CLK_PERIOD_PS       10000
`define SSR_TICK_CYCLES         (`SSR_TICK_PS / `SSR_CLK_PERIOD_PS)

`endif

// File: logic/ssr_time_counter.v
/*
 * Free-running 24-bit time counter whose lowest bit is one time tick.
 * Assumes one clock; the tick length is given in clock cycles.
 */
`default_nettype none

module ssr_time_counter #(
    parameter integer TICK_CYCLES = 3906
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    output reg  [23:0] count_o
);

    reg [31:0] prescale;

    // Fractional tick length is truncated: 39.0625 us is 3906.25 cycles
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale <= 32'h0;
            count_o  <= 24'h0;
        end else if (prescale == TICK_CYCLES - 1) begin
            prescale <= 32'h0;
            count_o  <= count_o + 24'h1;
        end else begin
            prescale <= prescale + 32'h1;
        end
    end

endmodule // ssr_time_counter

`default_nettype wire

// File: logic/ssr_status_readout.v
/*
 * Read-only status and result registers of a motion sensor: time counter high
 * byte, power-on flag, two clear-on-read interrupt status registers, step count,
 * temperature and FIFO fill level, plus a summary interrupt.
 * Assumes the producers of events and values run on sys_clk_i; event inputs are
 * one-cycle pulses or levels, each high cycle setting its flag.
 */
`include "ssr_regs.vh"
`default_nettype none

module ssr_status_readout #(
    parameter integer TICK_CYCLES = `SSR_TICK_CYCLES,
    parameter integer FIFO_CNT_W  = 14
) (
    input  wire                  sys_clk_i,
    input  wire                  rst_i,
    input  wire                  soft_reset_i,
    input  wire [7:0]            addr_i,
    input  wire [7:0]            wdata_i,
    input  wire                  wr_i,
    input  wire                  rd_i,
    output reg  [7:0]            rdata_o,
    input  wire [7:0]            feat_event_i,
    input  wire [7:0]            data_event_i,
    input  wire [31:0]           step_count_i,
    input  wire [7:0]            temperature_i,
    input  wire [FIFO_CNT_W-1:0] fifo_count_i,
    output wire [23:0]           time_count_o,
    output wire                  irq_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg        por_flag;
    reg  [7:0] feat_status;
    reg  [7:0] data_status;
    reg  [7:0] irq_enable;
    reg  [7:0] irq_status;
    wire [7:0] feat_set;
    wire [7:0] data_set;
    wire [7:0] irq_events;
    wire [7:0] irq_clear;
    wire [15:0] fifo_wide;

    function rd_hit;
        input [7:0] addr;
        input [7:0] target;
        input       strobe;
        begin
            rd_hit = strobe && (addr == target);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Time counter
    // ------------------------------------------------------------------------
    ssr_time_counter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_time (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .count_o   (time_count_o)
    );

    // ------------------------------------------------------------------------
    // Clear-on-read flags
    // ------------------------------------------------------------------------
    assign feat_set = feat_event_i & `SSR_FEAT_MASK;
    assign data_set = data_event_i & `SSR_DATA_MASK;

    // Set wins over read clear so no event is dropped
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_flag    <= 1'b1;
            feat_status <= `SSR_ZERO;
            data_status <= `SSR_ZERO;
        end else begin
            if (soft_reset_i)
                por_flag <= 1'b1;
            else if (rd_hit(addr_i, `SSR_ADDR_POR_EVENT, rd_i))
                por_flag <= 1'b0;
            if (rd_hit(addr_i, `SSR_ADDR_FEAT_STATUS, rd_i))
                feat_status <= feat_set;
            else
                feat_status <= feat_status | feat_set;
            if (rd_hit(addr_i, `SSR_ADDR_DATA_STATUS, rd_i))
                data_status <= data_set;
            else
                data_status <= data_status | data_set;
        end
    end

    // ------------------------------------------------------------------------
    // Summary interrupt: sticky, enable, write-one-to-clear
    // ------------------------------------------------------------------------
    assign irq_events = {5'h0, |data_set, |feat_set, soft_reset_i};
    assign irq_clear  = (wr_i && addr_i == `SSR_ADDR_IRQ_CLEAR) ? wdata_i : 8'h00;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_enable <= `SSR_ZERO;
            irq_status <= `SSR_ZERO;
        end else begin
            if (wr_i && addr_i == `SSR_ADDR_IRQ_ENABLE)
                irq_enable <= wdata_i & `SSR_IRQ_MASK;
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    assign irq_o = |(irq_status & irq_enable);

    // ------------------------------------------------------------------------
    // Read port; writes are ignored except to irq_enable (0x30) and the irq clear register (0x32)
    // ------------------------------------------------------------------------
    assign fifo_wide = {{(16-FIFO_CNT_W){1'b0}}, fifo_count_i};

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `SSR_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                `SSR_ADDR_TIME_HIGH:   rdata_o <= time_count_o[23:16];
                `SSR_ADDR_POR_EVENT:   rdata_o <= {7'h0, por_flag};
                `SSR_ADDR_FEAT_STATUS: rdata_o <= feat_status;
                `SSR_ADDR_DATA_STATUS: rdata_o <= data_status;
                `SSR_ADDR_STEP0:       rdata_o <= step_count_i[7:0];
                `SSR_ADDR_STEP1:       rdata_o <= step_count_i[15:8];
                `SSR_ADDR_STEP2:       rdata_o <= step_count_i[23:16];
                `SSR_ADDR_STEP3:       rdata_o <= step_count_i[31:24];
                `SSR_ADDR_TEMPERATURE: rdata_o <= temperature_i;
                `SSR_ADDR_FIFO_LOW:    rdata_o <= fifo_wide[7:0];
                `SSR_ADDR_FIFO_HIGH:   rdata_o <= fifo_wide[15:8] & `SSR_FIFO_HIGH_MASK;
                `SSR_ADDR_IRQ_ENABLE:  rdata_o <= irq_enable;
                `SSR_ADDR_IRQ_STATUS:  rdata_o <= irq_status;
                default:               rdata_o <= `SSR_ZERO;
            endcase
        end else begin
            rdata_o <= `SSR_ZERO;
        end
    end
    // no write path exists to any status register above except irq_enable and the write-one-to-clear of irq_status

endmodule // ssr_status_readout

`default_nettype wire

// File: verif/ssr_status_readout_sva.sv
/* Checker on the status readout ports.
   Assumes one clock and a tick of 4 cycles. */
`default_nettype none
module ssr_status_readout_sva #(
    parameter integer TICK_CYCLES = 4,
    parameter integer FIFO_CNT_W  = 14
) (
    input wire logic                  sys_clk_i, rst_i, soft_reset_i, wr_i, rd_i, irq_o,
    input wire logic [7:0]            addr_i, wdata_i, rdata_o, feat_event_i, data_event_i, temperature_i,
    input wire logic [31:0]           step_count_i,
    input wire logic [FIFO_CNT_W-1:0] fifo_count_i,
    input wire logic [23:0]           time_count_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ----
    // Read path
    // ----
    rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    time_rd_a: assert property (rd_i && addr_i == 8'h1A |=> rdata_o == $past(time_count_o[23:16]))
        else $error("time byte wrong");
    step_rd_a: assert property (rd_i && addr_i >= 8'h1E && addr_i <= 8'h21
        |=> rdata_o == 8'($past(step_count_i) >> (8 * ($past(addr_i) - 8'h1E)))) else $error("step byte wrong");
    temp_rd_a: assert property (rd_i && addr_i == 8'h22 |=> rdata_o == $past(temperature_i))
        else $error("temperature wrong");
    fifo_low_a: assert property (rd_i && addr_i == 8'h24 |=> rdata_o == $past(fifo_count_i[7:0]))
        else $error("fifo low wrong");
    fifo_high_a: assert property (rd_i && addr_i == 8'h25 |=> rdata_o == {2'b00, $past(fifo_count_i[13:8])})
        else $error("fifo high wrong");
    // Fixed repeat matches the bench tick of 4
    time_tick_a: assert property ($changed(time_count_o) |=> $stable(time_count_o) [*3]
        ##1 time_count_o == $past(time_count_o) + 24'h1) else $error("time tick wrong");
    por_clear_a: assert property (rd_i && addr_i == 8'h1B && !soft_reset_i ##1 rd_i && addr_i == 8'h1B
        |=> rdata_o == 8'h00) else $error("flag not cleared");
    feat_clear_a: assert property (rd_i && addr_i == 8'h1C ##1 rd_i && addr_i == 8'h1C
        |=> rdata_o == ($past(feat_event_i, 2) & 8'hEE)) else $error("feature status wrong");
    data_clear_a: assert property (rd_i && addr_i == 8'h1D ##1 rd_i && addr_i == 8'h1D
        |=> rdata_o == ($past(data_event_i, 2) & 8'hA3)) else $error("data status wrong");
endmodule // ssr_status_readout_sva
bind ssr_status_readout ssr_status_readout_sva #(.TICK_CYCLES(TICK_CYCLES), .FIFO_CNT_W(FIFO_CNT_W)) sva_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .wr_i(wr_i), .rd_i(rd_i), .irq_o(irq_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .feat_event_i(feat_event_i),
    .data_event_i(data_event_i), .temperature_i(temperature_i), .step_count_i(step_count_i),
    .fifo_count_i(fifo_count_i), .time_count_o(time_count_o));
`default_nettype wire

// File: verif/ssr_host_model.sv
/* Host on the register port: one-cycle write strobe, read strobe of one cycle or two when twice is set.
   Assumes one caller at a time. */
`default_nettype none
module ssr_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
    endtask
    // Two back-to-back reads of one address when twice is set
    task automatic rd(input logic [7:0] a, input logic twice, output logic [7:0] d0, output logic [7:0] d1);
        @(posedge sys_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= twice;
        #1 d0 = rdata_i;
        d1 = 8'h00;
        if (twice) begin
            @(posedge sys_clk_i);
            rd_o <= 1'b0;
            #1 d1 = rdata_i;
        end
    endtask
endmodule // ssr_host_model
`default_nettype wire

// File: verif/ssr_status_readout_tb_top.sv
/* Bench for the status readout block.
   Assumes a tick of 4 cycles. */
`default_nettype none
module ssr_status_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, soft_reset_i = 1'b0, wr_i, rd_i, irq_o;
    logic [7:0]  addr_i, wdata_i, rdata_o, d0, d1, feat_event_i = 8'h00, data_event_i = 8'h00;
    logic [7:0]  temperature_i = 8'h00;
    logic [31:0] step_count_i = 32'h0;
    logic [13:0] fifo_count_i = 14'h0;
    logic [23:0] time_count_o, t0;
    int          mismatches = 0, total_checks = 0;
    ssr_status_readout #(.TICK_CYCLES(4), .FIFO_CNT_W(14)) ssr_status_readout_inst (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .soft_reset_i(soft_reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .feat_event_i(feat_event_i), .data_event_i(data_event_i),
        .step_count_i(step_count_i), .temperature_i(temperature_i), .fifo_count_i(fifo_count_i),
        .time_count_o(time_count_o), .irq_o(irq_o));
    ssr_host_model ssr_host_model_inst (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic two);
        ssr_host_model_inst.rd(a, two, d0, d1);
    endtask
    task automatic pulse(input logic [7:0] f, input logic [7:0] d);
        @(posedge sys_clk_i);
        feat_event_i <= f;
        data_event_i <= d;
        @(posedge sys_clk_i);
        feat_event_i <= 8'h00;
        data_event_i <= 8'h00;
    endtask
    task automatic t_reset;
        rd(8'h1B, 1'b1);
        chk(d0, 8'h01);
        chk(d1, 8'h00);
        rd(8'h3F, 1'b0);
        chk(d0, 8'h00);
        chk(irq_o, 1'b0);
        $display("t_reset done");
    endtask
    task automatic t_values;
        logic [7:0] adr [7] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25};
        logic [7:0] val [7] = '{8'hEF, 8'hCD, 8'hAB, 8'h89, 8'hF6, 8'h5C, 8'h2A};
        @(posedge sys_clk_i);
        step_count_i <= 32'h89ABCDEF;
        temperature_i <= 8'hF6;
        fifo_count_i <= 14'h2A5C;
        for (int a = 8'h1A; a <= 8'h25; a++) ssr_host_model_inst.wr(8'(a), 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(adr[i], 1'b0);
            chk(d0, val[i]);
        end
        rd(8'h1C, 1'b0);
        chk(d0, 8'h00);
        $display("t_values done");
    endtask
    task automatic t_cor;
        pulse(8'hFF, 8'hFF);
        fork
            rd(8'h1C, 1'b1);
            pulse(8'h42, 8'h81);
        join
        chk({d0, d1}, 16'hEE42);
        rd(8'h1D, 1'b0);
        chk(d0, 8'hA3);
        $display("t_cor done");
    endtask
    task automatic t_irq;
        ssr_host_model_inst.wr(8'h32, 8'h07);
        ssr_host_model_inst.wr(8'h30, 8'h02);
        pulse(8'h00, 8'h01);
        #1 chk(irq_o, 1'b0);
        pulse(8'h02, 8'h00);
        #1 chk(irq_o, 1'b1);
        ssr_host_model_inst.wr(8'h32, 8'h02);
        #1 chk(irq_o, 1'b0);
        @(posedge sys_clk_i);
        soft_reset_i <= 1'b1;
        @(posedge sys_clk_i);
        soft_reset_i <= 1'b0;
        rd(8'h31, 1'b0);
        chk(d0, 8'h05);
        rd(8'h1B, 1'b0);
        chk(d0, 8'h01);
        $display("t_irq done");
    endtask
    task automatic t_time;
        @(posedge sys_clk_i);
        #1 t0 = time_count_o;
        repeat (400) @(posedge sys_clk_i);
        #1 chk(time_count_o - t0, 24'h64);
        rd(8'h1A, 1'b0);
        chk(d0, 8'h00);
        $display("t_time done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_values;
        t_cor;
        t_irq;
        t_time;
        conclude;
    end
    initial begin
        #50us;
        mismatches++;
        conclude;
    end
endmodule // ssr_status_readout_tb_top
`default_nettype wire
